// file: hw/gwm_top.v
// gated windowed duty measurement timer with apb register access
//
// How it works
// - counter adds one each clock while measured signal is high, else holds; held at zero while disabled
// - each window rising edge after the first copies counter into latch
// - on those same window edges the counter restarts after capture
// - latch readable as three read-only bytes, unknown until first capture
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defs.vh"

module gwm_top (
  input  wire                    i_mclk,
  input  wire                    i_reset,
  input  wire                    i_psel,
  input  wire                    i_penable,
  input  wire                    i_pwrite,
  input  wire [`GWM_ADDR_W-1:0]  i_paddr,
  input  wire [`GWM_DATA_W-1:0]  i_pwdata,
  output reg  [`GWM_DATA_W-1:0]  o_prdata,
  output reg                     o_pready,
  output reg                     o_pslverr,
  input  wire                    i_measured_signal,
  input  wire                    i_window_input,
  output reg                     o_capture_strobe
);

  // ========================================================
  // address decode and byte widening helpers
  function is_mapped;
    input [`GWM_ADDR_W-1:0] a;
    begin
      is_mapped = (a == `GWM_ADDR_CTRL)   ||
                  (a == `GWM_ADDR_STATUS) ||
                  (a == `GWM_ADDR_COUNT)  ||
                  (a == `GWM_ADDR_CPR_LO) ||
                  (a == `GWM_ADDR_CPR_HI) ||
                  (a == `GWM_ADDR_CPR_UP);
    end
  endfunction

  function [`GWM_DATA_W-1:0] byte_word;
    input [`GWM_BYTE_W-1:0] b;
    begin
      byte_word = `GWM_DATA_ZERO;
      byte_word[`GWM_BYTE_W-1:0] = b;
    end
  endfunction

  // ========================================================
  // input synchronisers
  wire sig_s;
  wire win_s;

  gwm_sync u_sig_sync (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_async   (i_measured_signal),
    .o_level_q (sig_s)
  );

  gwm_sync u_win_sync (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_async   (i_window_input),
    .o_level_q (win_s)
  );

  // ========================================================
  // register select decode
  // one compare per register feeds both the write strobes and
  // the read mux, so the two can never disagree on the map
  function addr_is;
    input [`GWM_ADDR_W-1:0] a;
    input [`GWM_ADDR_W-1:0] target;
    begin
      addr_is = (a == target);
    end
  endfunction

  wire hit_ctrl;
  wire hit_status;
  wire hit_count;
  wire hit_cpr_lo;
  wire hit_cpr_hi;
  wire hit_cpr_up;
  wire hit_any;

  assign hit_ctrl   = addr_is(i_paddr, `GWM_ADDR_CTRL);
  assign hit_status = addr_is(i_paddr, `GWM_ADDR_STATUS);
  assign hit_count  = addr_is(i_paddr, `GWM_ADDR_COUNT);
  assign hit_cpr_lo = addr_is(i_paddr, `GWM_ADDR_CPR_LO);
  assign hit_cpr_hi = addr_is(i_paddr, `GWM_ADDR_CPR_HI);
  assign hit_cpr_up = addr_is(i_paddr, `GWM_ADDR_CPR_UP);
  assign hit_any    = is_mapped(i_paddr);

  // ========================================================
  // control and state registers
  reg                    enable_q;
  reg                    enable_d;
  reg                    armed_q;
  reg                    armed_d;
  reg                    captured_q;
  reg                    captured_d;
  reg                    win_prev_q;
  reg                    strobe_d;
  reg [`GWM_CNT_W-1:0]   cpr_q;
  reg [`GWM_CNT_W-1:0]   cpr_d;
  wire [`GWM_CNT_W-1:0]  count;

  wire win_rise = win_s & ~win_prev_q;
  // the first edge after enabling only opens the first window
  wire capture  = enable_q & armed_q & win_rise;

  // ========================================================
  // high-time counter
  gwm_counter u_counter (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_run     (enable_q),
    .i_gate    (sig_s),
    .i_restart (capture),
    .o_count_q (count)
  );

  // ========================================================
  // apb access phase qualifiers
  wire setup_ph  = i_psel & ~i_penable;
  wire access_ok = i_psel & i_penable & o_pready;
  wire rd_setup  = setup_ph & ~i_pwrite;
  wire wr_acc    = access_ok & i_pwrite & hit_any;
  wire wr_ctrl   = wr_acc & hit_ctrl;
  wire wr_status = wr_acc & hit_status;
  wire clr_capt  = wr_status & i_pwdata[`GWM_STAT_CAPT_BIT];

  // ========================================================
  // enable next state
  always @* begin
    enable_d = enable_q;
    if (wr_ctrl) begin
      enable_d = i_pwdata[`GWM_CTRL_EN_BIT];
    end
  end

  // ========================================================
  // window arming
  // dropping the arm on disable makes every restart skip its
  // first window edge again, as a fresh start would
  always @* begin
    armed_d = armed_q;
    if (!enable_q) begin
      armed_d = 1'h0;
    end else if (win_rise) begin
      armed_d = 1'h1;
    end
  end

  // ========================================================
  // sticky capture flag
  // a capture in the same cycle as a clear keeps the flag set
  always @* begin
    captured_d = captured_q;
    if (capture) begin
      captured_d = 1'h1;
    end else if (clr_capt) begin
      captured_d = 1'h0;
    end
  end

  // ========================================================
  // capture strobe and latch next state
  always @* begin
    strobe_d = capture;
    cpr_d    = cpr_q;
    if (capture) begin
      cpr_d = count;
    end
  end

  // ========================================================
  // state registers
  always @(posedge i_mclk) begin
    if (i_reset) begin
      enable_q <= `GWM_CTRL_RST;
    end else begin
      enable_q <= enable_d;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      armed_q <= 1'h0;
    end else begin
      armed_q <= armed_d;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      captured_q <= 1'h0;
    end else begin
      captured_q <= captured_d;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      win_prev_q <= 1'h0;
    end else begin
      win_prev_q <= win_s;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_capture_strobe <= 1'h0;
    end else begin
      o_capture_strobe <= strobe_d;
    end
  end

  // latch deliberately has no reset: it reads unknown until captured
  always @(posedge i_mclk) begin
    cpr_q <= cpr_d;
  end

  // ========================================================
  // register words
  reg [`GWM_DATA_W-1:0] ctrl_word;
  reg [`GWM_DATA_W-1:0] status_word;

  always @* begin
    ctrl_word                        = `GWM_DATA_ZERO;
    ctrl_word[`GWM_CTRL_EN_BIT]      = enable_q;
    status_word                      = `GWM_DATA_ZERO;
    status_word[`GWM_STAT_ARMED_BIT] = armed_q;
    status_word[`GWM_STAT_CAPT_BIT]  = captured_q;
    status_word[`GWM_STAT_SIG_BIT]   = sig_s;
    status_word[`GWM_STAT_WIN_BIT]   = win_s;
  end

  // ========================================================
  // read mux
  // the select wires are one-hot, so the order of the chain
  // does not matter; unmapped addresses hit none and read as zero
  reg [`GWM_DATA_W-1:0] rdata_d;

  always @* begin
    rdata_d = `GWM_DATA_ZERO;
    if (hit_ctrl) begin
      rdata_d = ctrl_word;
    end else if (hit_status) begin
      rdata_d = status_word;
    end else if (hit_count) begin
      rdata_d[`GWM_CNT_W-1:0] = count;
    end else if (hit_cpr_lo) begin
      rdata_d = byte_word(cpr_q[`GWM_BYTE0_LSB +: `GWM_BYTE_W]);
    end else if (hit_cpr_hi) begin
      rdata_d = byte_word(cpr_q[`GWM_BYTE1_LSB +: `GWM_BYTE_W]);
    end else if (hit_cpr_up) begin
      rdata_d = byte_word(cpr_q[`GWM_BYTE2_LSB +: `GWM_BYTE_W]);
    end
  end

  // ========================================================
  // apb response next state
  // data is sampled in setup, so a capture during the access
  // cycle is seen by the next read, not this one
  reg [`GWM_DATA_W-1:0] prdata_d;
  reg                   pready_d;
  reg                   pslverr_d;

  always @* begin
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~hit_any;
    prdata_d  = o_prdata;
    if (rd_setup) begin
      prdata_d = rdata_d;
    end else if (!i_psel) begin
      prdata_d = `GWM_DATA_ZERO;
    end
  end

  // ========================================================
  // apb response: one access cycle, no wait states
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_pready <= 1'h0;
    end else begin
      o_pready <= pready_d;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_pslverr <= 1'h0;
    end else begin
      o_pslverr <= pslverr_d;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_prdata <= `GWM_DATA_ZERO;
    end else begin
      o_prdata <= prdata_d;
    end
  end

endmodule // gwm_top

`default_nettype wire

// file: hw/gwm_defs.vh
// constants for the gated windowed duty measurement block
`ifndef GWM_DEFS_VH
`define GWM_DEFS_VH

// ==========================================================
// widths
`define GWM_CNT_W        24
`define GWM_ADDR_W       8
`define GWM_DATA_W       32

// ==========================================================
// register byte addresses on the apb bus
`define GWM_ADDR_CTRL    8'h00
`define GWM_ADDR_STATUS  8'h04
`define GWM_ADDR_COUNT   8'h08
`define GWM_ADDR_CPR_LO  8'h0c
`define GWM_ADDR_CPR_HI  8'h10
`define GWM_ADDR_CPR_UP  8'h14

// ==========================================================
// field positions
`define GWM_CTRL_EN_BIT      0
`define GWM_STAT_ARMED_BIT   0
`define GWM_STAT_CAPT_BIT    1
`define GWM_STAT_SIG_BIT     2
`define GWM_STAT_WIN_BIT     3
`define GWM_BYTE0_LSB        0
`define GWM_BYTE1_LSB        8
`define GWM_BYTE2_LSB        16
`define GWM_BYTE_W           8

// ==========================================================
// reset values and small constants
`define GWM_CTRL_RST     1'h0
`define GWM_CNT_ZERO     24'h000000
`define GWM_CNT_ONE      24'h000001
`define GWM_DATA_ZERO    32'h00000000

`endif

// file: hw/gwm_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module gwm_sync (
  input  wire i_mclk,
  input  wire i_reset,
  input  wire i_async,
  output reg  o_level_q
);

  // ========================================================
  // synchroniser chain
  // stage one feeds stage two only, to keep metastability contained
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge i_mclk) begin
    if (i_reset) begin
      s1_q      <= 1'h0;
      s2_q      <= 1'h0;
      s3_q      <= 1'h0;
      o_level_q <= 1'h0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change only counts once two settled stages agree
      if (s2_q == s3_q) begin
        o_level_q <= s3_q;
      end
    end
  end

endmodule // gwm_sync

`default_nettype wire

// file: hw/gwm_counter.v
// gated 24-bit high-time counter with synchronous restart
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defs.vh"

module gwm_counter (
  input  wire                    i_mclk,
  input  wire                    i_reset,
  input  wire                    i_run,
  input  wire                    i_gate,
  input  wire                    i_restart,
  output reg  [`GWM_CNT_W-1:0]   o_count_q
);

  // ========================================================
  // count register
  // wraps at full scale; no overflow flag in this mode
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_count_q <= `GWM_CNT_ZERO;
    end else if (!i_run) begin
      o_count_q <= `GWM_CNT_ZERO;
    end else if (i_restart) begin
      // the restart cycle itself is counted if the signal is high,
      // so no high time is lost across a window boundary
      o_count_q <= i_gate ? `GWM_CNT_ONE : `GWM_CNT_ZERO;
    end else if (i_gate) begin
      o_count_q <= o_count_q + `GWM_CNT_ONE;
    end
  end

endmodule // gwm_counter

`default_nettype wire

// file: tb/gwm_checker.sv
// port checker for the gated window measurement block
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defs.vh"
// ========
// checker
module gwm_checker (
  input wire logic                   i_mclk,
  input wire logic                   i_reset,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`GWM_ADDR_W-1:0] i_paddr,
  input wire logic [`GWM_DATA_W-1:0] i_pwdata,
  input wire logic [`GWM_DATA_W-1:0] o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic                   i_measured_signal,
  input wire logic                   i_window_input,
  input wire logic                   o_capture_strobe
);
  logic [3:0] win_age_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // saturating age of the last high window level
  always @(posedge i_mclk) begin
    if (i_reset) win_age_q <= 4'hf;
    else if (i_window_input) win_age_q <= 4'h0;
    else if (win_age_q != 4'hf) win_age_q <= win_age_q + 4'h1;
  end
  a_ready_after_setup: assert property (
    i_psel && !i_penable |=> o_pready) else $error("no ready");
  a_ready_single: assert property (
    o_pready |=> !o_pready) else $error("ready too long");
  a_err_with_ready: assert property (
    o_pslverr |-> o_pready && i_psel && i_penable)
    else $error("stray error");
  a_idle_data_zero: assert property (
    !i_psel && !$past(i_psel) |-> o_prdata == 32'h0)
    else $error("idle data");
  a_strobe_one_shot: assert property (
    o_capture_strobe |=> !o_capture_strobe [*3])
    else $error("strobe repeats");
  a_strobe_needs_win: assert property (
    o_capture_strobe |-> win_age_q <= 4'h8)
    else $error("strobe without window");
  a_sync_delay_win: assert property (
    $rose(i_window_input) |-> !o_capture_strobe [*3])
    else $error("window not synchronised");
  cover property (o_capture_strobe);
  cover property (o_pslverr);
  cover property (i_pwrite && o_pready);
endmodule // gwm_checker
bind gwm_top gwm_checker gwm_checker_inst (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_measured_signal(i_measured_signal),
  .i_window_input(i_window_input), .o_capture_strobe(o_capture_strobe));
`default_nettype wire

// file: tb/gwm_src_model.sv
// model of the measured signal and window sources
`timescale 1ns/10ps
`default_nettype none
// ========
// sources
module gwm_src_model (
  input  wire logic i_mclk,
  output var  logic o_sig,
  output var  logic o_win
);
  initial o_sig = 1'b0;
  initial o_win = 1'b0;
  // four low clocks after each pulse keep it clear of the runt filter
  task automatic pulse(input int n);
    @(posedge i_mclk) o_sig <= 1'b1;
    repeat (n) @(posedge i_mclk);
    o_sig <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic win_edge();
    @(posedge i_mclk) o_win <= 1'b1;
    repeat (12) @(posedge i_mclk);
    o_win <= 1'b0;
    repeat (12) @(posedge i_mclk);
  endtask
endmodule // gwm_src_model
`default_nettype wire

// file: tb/gwm_top_tb.sv
// self-checking bench for the gated window measurement block
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defs.vh"
// ========
// bench
module gwm_top_tb;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0, rd, got, x;
  logic [31:0] rng = 32'h000151c2;
  logic        rdy, err, sig, win, stb, e;
  int          n_fail = 0, n_checks = 0, n_stb = 0, a, b;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) n_stb <= n_stb + 1;
  gwm_top gwm_top_inst (.i_mclk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .i_measured_signal(sig), .i_window_input(win),
    .o_capture_strobe(stb));
  gwm_src_model gwm_src_model_inst (.i_mclk(clk), .o_sig(sig),
    .o_win(win));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // the latch is 24 bits wide, so the expected sum wraps there
  function automatic logic [31:0] cpr_exp(input int p, input int q);
    return (p + q) & 32'h00ffffff;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] v);
    n_checks++;
    if (g !== v) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= ad;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    got = rd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    chk({got[30:0], e}, 32'h1);
    apb(1'b1, `GWM_ADDR_CTRL, 32'h1);
    gwm_src_model_inst.win_edge();
    chk(n_stb, 0);
    for (int k = 0; k < 5; k++) begin
      rng = nxt(rng);
      a = 3 + rng % 200;
      rng = nxt(rng);
      b = 3 + rng % 150;
      if (k == 0) begin
        a = 3;
        b = 3;
      end
      if (k == 1) a = 300;
      gwm_src_model_inst.pulse(a);
      gwm_src_model_inst.pulse(b);
      gwm_src_model_inst.win_edge();
      chk(n_stb, k + 1);
      // a write to a read-only byte must leave the latch alone
      apb(1'b1, `GWM_ADDR_CPR_LO, 32'hff);
      x = 32'h0;
      for (int i = 0; i < 3; i++) begin
        apb(1'b0, `GWM_ADDR_CPR_LO + 8'(4 * i), 32'h0);
        x[8 * i +: 8] = got[7:0];
      end
      chk(x, cpr_exp(a, b));
      apb(1'b0, `GWM_ADDR_COUNT, 32'h0);
      chk(got, 32'h0);
      $display("test %0d done", k);
    end
    // flags: armed and captured set, mapped read gives no error
    apb(1'b0, `GWM_ADDR_STATUS, 32'h0);
    chk({got[30:0], e}, 32'h6);
    apb(1'b1, `GWM_ADDR_STATUS, 32'h2);
    apb(1'b0, `GWM_ADDR_STATUS, 32'h0);
    chk(got, 32'h1);
    // a restart of the mode must again only arm on its first edge
    apb(1'b1, `GWM_ADDR_CTRL, 32'h0);
    apb(1'b1, `GWM_ADDR_CTRL, 32'h1);
    apb(1'b0, `GWM_ADDR_CTRL, 32'h0);
    chk(got, 32'h1);
    gwm_src_model_inst.win_edge();
    chk(n_stb, 5);
    $display("test flags done");
    stop_test;
  end
endmodule // gwm_top_tb
`default_nettype wire
